// *** include/ring_dma_map.vh ***
`ifndef RING_DMA_MAP_VH
`define RING_DMA_MAP_VH
// Channel identifiers
`define CH_TX0 3'h0
`define CH_TX3 3'h3
`define CH_RX4 3'h4
`define CH_RX5 3'h5
`define CH_CMD6 3'h6
`define CH_CMD7 3'h7
// Descriptor type codes
`define DT_GEN 2'h0
`define DT_TXB 2'h1
`define DT_RXB 2'h2
`define DT_COPY 2'h3
// Spare port modes
`define PM_IDLE 2'h0
`define PM_WIDE64 2'h1
`define PM_ADDR 2'h2
// Frame buffer size in bytes and descriptor queue depth
`define FRAME_BUF_BYTES 8192
`define DESC_QUEUE_DEPTH 20
// Queue record bit positions, type code sits in bits 1:0
`define REC_FIRST 2
`define REC_LAST 3
`define REC_SRC 4
`define REC_DST 5
`define REC_FCS 6
`endif

// *** hw/frame_buffer_mem.v ***
`timescale 1ns/1ps
`default_nettype none
module frame_buffer_mem #(
  parameter AW = 13
)(
  input wire i_clock,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [7:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [7:0] o_rdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  // Registered read port
  always @(posedge i_clock)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule // frame_buffer_mem
`default_nettype wire

// *** hw/desc_queue.v ***
`timescale 1ns/1ps
`default_nettype none
module desc_queue #(
  parameter DEPTH = 20,
  parameter W = 8
)(
  input wire i_clock,
  input wire i_rst,
  input wire i_push,
  input wire [W-1:0] i_data,
  input wire i_pop,
  output wire [W-1:0] o_data,
  output wire o_full,
  output wire o_empty
);
  reg [W-1:0] q_r [0:DEPTH-1];
  reg [4:0] wp_r;
  reg [4:0] rp_r;
  reg [5:0] cnt_r;
  wire do_push = i_push && !o_full;
  wire do_pop = i_pop && !o_empty;
  assign o_full = (cnt_r == DEPTH);
  assign o_empty = (cnt_r == 6'h0);
  assign o_data = q_r[rp_r];
  // Circular pointers wrap at DEPTH
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wp_r <= 5'h0;
      rp_r <= 5'h0;
      cnt_r <= 6'h0;
    end
    else
    begin
      if (do_push)
      begin
        q_r[wp_r] <= i_data;
        wp_r <= (wp_r == DEPTH-1) ? 5'h0 : wp_r + 5'h1;
      end
      if (do_pop)
        rp_r <= (rp_r == DEPTH-1) ? 5'h0 : rp_r + 5'h1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 6'h1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 6'h1;
    end
  end
endmodule // desc_queue
`default_nettype wire

// *** hw/ring_channel_dma_router.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ring_dma_map.vh"
module ring_channel_dma_router #(
  parameter QDEPTH = `DESC_QUEUE_DEPTH,
  parameter BUF_AW = 13
)(
  input wire i_clock,
  input wire i_rst,
  // Per-channel port and staging selects, bit n for channel n, plus one shared spare mode
  input wire [7:0] i_port_sel,
  input wire [7:0] i_stage_en,
  input wire [1:0] i_spare_mode,
  // Descriptor offer from a ring fetch (owned descriptor)
  input wire i_desc_valid,
  input wire [2:0] i_desc_ch,
  input wire [1:0] i_desc_type,
  input wire i_desc_own,
  input wire i_desc_first,
  input wire i_desc_last,
  input wire i_desc_src_port,
  input wire i_desc_dst_port,
  input wire i_desc_fcs_sup,
  output reg [7:0] o_prefetch_ready,
  output reg o_desc_reject,
  // Frame byte staging path
  input wire i_stage_we,
  input wire [BUF_AW-1:0] i_stage_addr,
  input wire [7:0] i_stage_data,
  input wire [BUF_AW-1:0] i_buf_raddr,
  output reg [7:0] o_buf_rdata,
  // Transmit service towards the MAC
  input wire i_mac_ready,
  output reg o_tx_go,
  output reg [1:0] o_tx_ring,
  output reg o_tx_port,
  output reg o_tx_staged,
  output reg o_tx_first,
  output reg o_tx_last,
  output reg o_fcs_suppress,
  // Receive routing
  input wire i_rx_valid,
  input wire i_rx_ring,
  output reg o_rx_go,
  output reg o_rx_port,
  output reg o_rx_to_local,
  // Copy engine
  output reg o_copy_go,
  output reg [2:0] o_copy_ch,
  output reg o_copy_rd_port,
  output reg o_copy_wr_port,
  // Spare port behaviour
  output reg o_port_a_active,
  output reg o_port_b_active,
  output reg [1:0] o_spare_mode
);
  // ----------------------------------------------------------------
  // Descriptor admission
  // ----------------------------------------------------------------
  localparam QW = 7;
  wire [7:0] q_full;
  wire [7:0] q_empty;
  wire [QW-1:0] q_head [0:7];
  reg [7:0] q_pop;
  reg legal;
  wire is_tx = (i_desc_ch <= `CH_TX3);
  wire is_rx = (i_desc_ch == `CH_RX4) || (i_desc_ch == `CH_RX5);
  // Which types each channel class may hold
  always @*
  begin
    legal = 1'b0;
    if (is_rx)
      legal = (i_desc_type == `DT_RXB);
    else if (is_tx)
      legal = (i_desc_type == `DT_GEN) || (i_desc_type == `DT_TXB) ||
              ((i_desc_type == `DT_COPY) && !i_stage_en[i_desc_ch]);
    else
      legal = (i_desc_type != `DT_RXB);
  end
  wire accept = i_desc_valid && i_desc_own && legal && !q_full[i_desc_ch];
  // Queue record layout
  wire [QW-1:0] rec = {i_desc_fcs_sup, i_desc_dst_port, i_desc_src_port,
                       i_desc_last, i_desc_first, i_desc_type};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_q
      desc_queue #(.DEPTH(QDEPTH), .W(QW)) u_q (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_push(accept && (i_desc_ch == g)),
        .i_data(rec),
        .i_pop(q_pop[g]),
        .o_data(q_head[g]),
        .o_full(q_full[g]),
        .o_empty(q_empty[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // Staging memory and completion tracking
  // ----------------------------------------------------------------
  wire [7:0] buf_q;
  frame_buffer_mem #(.AW(BUF_AW)) u_buf (
    .i_clock(i_clock),
    .i_we(i_stage_we),
    .i_waddr(i_stage_addr),
    .i_wdata(i_stage_data),
    .i_raddr(i_buf_raddr),
    .o_rdata(buf_q)
  );
  // Set when a staged ring's last buffer has been copied in
  reg [3:0] staged_done_r;
  reg [3:0] tx_elig;
  integer k;
  // Separate loop index for the clocked process, so k has one driver
  integer p;
  always @*
  begin
    for (k = 0; k < 4; k = k + 1)
      // staged frame waits for full copy
      tx_elig[k] = !q_empty[k] && (q_head[k][1:0] == `DT_TXB) &&
                   (!i_stage_en[k] || staged_done_r[k]);
  end
  // ----------------------------------------------------------------
  // Transmit arbiter, one-hot state
  // ----------------------------------------------------------------
  localparam S_IDLE = 2'b01;
  localparam S_SEND = 2'b10;
  reg [1:0] st_r;
  reg [1:0] win;
  reg win_v;
  always @*
  begin
    win = 2'h0;
    win_v = 1'b1;
    if (tx_elig[0])
      win = 2'h0;
    else if (tx_elig[1])
      win = 2'h1;
    else if (tx_elig[2])
      win = 2'h2;
    else if (tx_elig[3])
      win = 2'h3;
    else
      win_v = 1'b0;
  end
  // Lowest-numbered non-empty copy-capable channel
  reg [2:0] cp_ch;
  reg cp_v;
  integer j;
  always @*
  begin
    cp_ch = 3'h0;
    cp_v = 1'b0;
    for (j = 7; j >= 0; j = j - 1)
      // copy sources tx 0-3 and cmd 6-7
      if ((j < 4 || j > 5) && !q_empty[j] && (q_head[j][1:0] == `DT_COPY))
      begin
        cp_ch = j[2:0];
        cp_v = 1'b1;
      end
  end
  // Pop decisions
  reg [7:0] gen_pop;
  integer m;
  always @*
  begin
    gen_pop = 8'h0;
    for (m = 0; m < 8; m = m + 1)
      // General commands retire in place without a data path
      if (!q_empty[m] && (q_head[m][1:0] == `DT_GEN))
        gen_pop[m] = 1'b1;
  end
  wire tx_fire = (st_r == S_IDLE) && win_v && i_mac_ready;
  wire rx_fire = i_rx_valid && !q_empty[{2'b10, i_rx_ring}];
  always @*
  begin
    q_pop = gen_pop;
    if (tx_fire)
      q_pop[{1'b0, win}] = 1'b1;
    // copy runs in the same cycle as tx and rx
    if (cp_v)
      q_pop[cp_ch] = 1'b1;
    if (rx_fire)
      q_pop[{2'b10, i_rx_ring}] = 1'b1;
  end
  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  wire [QW-1:0] txh = q_head[{1'b0, win}];
  wire [QW-1:0] cph = q_head[cp_ch];
  wire [2:0] rxc = {2'b10, i_rx_ring};
  // Port usage across rings decides spare-port role
  wire any_a = |(~i_port_sel[5:0]);
  wire any_b = |i_port_sel[5:0];
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_r <= S_IDLE;
      staged_done_r <= 4'h0;
      o_prefetch_ready <= 8'h0;
      o_desc_reject <= 1'b0;
      o_buf_rdata <= 8'h0;
      o_tx_go <= 1'b0;
      o_tx_ring <= 2'h0;
      o_tx_port <= 1'b0;
      o_tx_staged <= 1'b0;
      o_tx_first <= 1'b0;
      o_tx_last <= 1'b0;
      o_fcs_suppress <= 1'b0;
      o_rx_go <= 1'b0;
      o_rx_port <= 1'b0;
      o_rx_to_local <= 1'b0;
      o_copy_go <= 1'b0;
      o_copy_ch <= 3'h0;
      o_copy_rd_port <= 1'b0;
      o_copy_wr_port <= 1'b0;
      o_port_a_active <= 1'b0;
      o_port_b_active <= 1'b0;
      o_spare_mode <= `PM_IDLE;
    end
    else
    begin
      o_prefetch_ready <= ~q_full;
      o_desc_reject <= i_desc_valid && (!legal || !i_desc_own);
      o_buf_rdata <= buf_q;
      // Staged completion marks set on last-buffer copy, cleared on last-buffer send
      // One mark per ring: a new completion outranks a clear in the same cycle
      for (p = 0; p < 4; p = p + 1)
        if (accept && (i_desc_ch == p) && i_desc_last && i_stage_en[p])
          staged_done_r[p] <= 1'b1;
        else if (tx_fire && (win == p) && txh[`REC_LAST])
          staged_done_r[p] <= 1'b0;
      st_r <= tx_fire ? S_SEND : S_IDLE;
      o_tx_go <= tx_fire;
      if (tx_fire)
      begin
        o_tx_ring <= win;
        o_tx_port <= i_port_sel[{1'b0, win}];
        o_tx_staged <= i_stage_en[{1'b0, win}];
        o_tx_first <= txh[`REC_FIRST];
        o_tx_last <= txh[`REC_LAST];
        o_fcs_suppress <= txh[`REC_FCS];
      end
      o_rx_go <= rx_fire;
      if (rx_fire)
      begin
        o_rx_port <= i_port_sel[rxc];
        o_rx_to_local <= i_stage_en[rxc];
      end
      o_copy_go <= cp_v;
      if (cp_v)
      begin
        o_copy_ch <= cp_ch;
        o_copy_rd_port <= cph[`REC_SRC];
        o_copy_wr_port <= cph[`REC_DST];
      end
      o_port_a_active <= any_a;
      o_port_b_active <= any_b;
      // spare port role when one port busy
      o_spare_mode <= (any_a ^ any_b) ? i_spare_mode : `PM_IDLE;
    end
  end
endmodule // ring_channel_dma_router
`default_nettype wire

// *** bench/ring_channel_dma_router_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_channel_dma_router_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_port_sel,
  input wire logic [7:0] i_stage_en,
  input wire logic i_desc_valid,
  input wire logic [2:0] i_desc_ch,
  input wire logic [1:0] i_desc_type,
  input wire logic i_desc_own,
  input wire logic i_rx_valid,
  input wire logic i_rx_ring,
  input wire logic o_desc_reject,
  input wire logic o_tx_go,
  input wire logic [1:0] o_tx_ring,
  input wire logic o_tx_port,
  input wire logic o_tx_staged,
  input wire logic o_rx_go,
  input wire logic o_rx_port,
  input wire logic o_rx_to_local,
  input wire logic o_copy_go,
  input wire logic [2:0] o_copy_ch,
  input wire logic o_port_a_active,
  input wire logic o_port_b_active,
  input wire logic [1:0] o_spare_mode
);
  // --------------------------------
  // Offer refusal and routing checks
  // --------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_rx_ring_only: assert property (i_desc_valid && i_desc_own && i_desc_ch[2:1] == 2'b10 && i_desc_type != 2'h2
    |=> o_desc_reject) else $error("receive ring took another descriptor type");
  a_cmd_no_rx: assert property (i_desc_valid && i_desc_own && i_desc_ch[2:1] == 2'b11 && i_desc_type == 2'h2
    |=> o_desc_reject) else $error("command channel took a receive descriptor");
  a_staged_copy: assert property (i_desc_valid && !i_desc_ch[2] && i_desc_type == 2'h3 && i_stage_en[i_desc_ch]
    |=> o_desc_reject) else $error("staged ring took a copy");
  a_unowned_reject: assert property (i_desc_valid && !i_desc_own |=> o_desc_reject)
    else $error("unowned descriptor taken");
  a_tx_port: assert property (o_tx_go |-> o_tx_port == i_port_sel[o_tx_ring])
    else $error("transmit on wrong port");
  a_tx_staged: assert property (o_tx_go |-> o_tx_staged == i_stage_en[o_tx_ring])
    else $error("transmit staging mismatch");
  a_rx_cause: assert property (o_rx_go |-> $past(i_rx_valid) && o_rx_port == i_port_sel[{2'b10, $past(i_rx_ring)}])
    else $error("receive without cause or on wrong port");
  a_rx_local: assert property (o_rx_go |-> o_rx_to_local == i_stage_en[{2'b10, $past(i_rx_ring)}])
    else $error("receive staging mismatch");
  a_copy_legal: assert property (o_copy_go |-> (!o_copy_ch[2] ? !i_stage_en[o_copy_ch] : o_copy_ch[1]))
    else $error("copy on an illegal channel");
  // spare mode only with one port
  a_spare_both: assert property (o_port_a_active && o_port_b_active && $past(o_port_a_active && o_port_b_active)
    |-> o_spare_mode == 2'h0) else $error("spare mode while both ports busy");
endmodule // ring_channel_dma_router_checker
bind ring_channel_dma_router ring_channel_dma_router_checker u_ring_channel_dma_router_checker (.i_clock, .i_rst,
  .i_port_sel, .i_stage_en, .i_desc_valid, .i_desc_ch, .i_desc_type, .i_desc_own, .i_rx_valid, .i_rx_ring,
  .o_desc_reject, .o_tx_go, .o_tx_ring, .o_tx_port, .o_tx_staged, .o_rx_go, .o_rx_port, .o_rx_to_local,
  .o_copy_go, .o_copy_ch, .o_port_a_active, .o_port_b_active, .o_spare_mode);
`default_nettype wire

// *** bench/mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  input wire logic i_clock,
  input wire logic i_stall,
  input wire logic i_tx_go,
  output logic o_ready = 1'b0,
  output logic [7:0] o_sent = 8'h00
);
  // --------------
  // MAC side model
  // --------------
  // trailer and check belong to the MAC, so every transmit go is counted, first buffer or not
  always @(posedge i_clock)
  begin
    o_ready <= !i_stall;
    if (i_tx_go)
      o_sent <= o_sent + 8'h01;
  end
endmodule // mac_model
`default_nettype wire

// *** bench/ring_channel_dma_router_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ring_dma_map.vh"
module ring_channel_dma_router_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_port_sel = 8'h22;
  logic [7:0] i_stage_en = 8'h24;
  logic [1:0] i_spare_mode = `PM_WIDE64;
  logic i_desc_valid = 1'b0, i_desc_own = 1'b0, i_desc_first = 1'b0, i_desc_last = 1'b0;
  logic i_desc_src_port = 1'b0, i_desc_dst_port = 1'b0, i_desc_fcs_sup = 1'b0;
  logic [2:0] i_desc_ch = 3'h0;
  logic [1:0] i_desc_type = 2'h0;
  logic i_stage_we = 1'b0, i_rx_valid = 1'b0, i_rx_ring = 1'b0, i_mac_ready, stall = 1'b0;
  logic [12:0] i_stage_addr = 13'h0000, i_buf_raddr = 13'h0000;
  logic [7:0] i_stage_data = 8'h00, o_prefetch_ready, o_buf_rdata, sent;
  logic o_desc_reject, o_tx_go, o_tx_port, o_tx_staged, o_tx_first, o_tx_last, o_fcs_suppress;
  logic o_rx_go, o_rx_port, o_rx_to_local, o_copy_go, o_copy_rd_port, o_copy_wr_port;
  logic o_port_a_active, o_port_b_active;
  logic [1:0] o_tx_ring, o_spare_mode;
  logic [2:0] o_copy_ch;
  int miscompares = 0;
  int samples_checked = 0;
  wire logic [2:0] gos = {o_copy_go, o_rx_go, o_tx_go};
  ring_channel_dma_router u_ring_channel_dma_router (.*);
  mac_model u_mac_model (.i_clock(i_clock), .i_stall(stall), .i_tx_go(o_tx_go), .o_ready(i_mac_ready), .o_sent(sent));
  // ---------------
  // Helpers
  // ---------------
  always #25 i_clock = ~i_clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One offer, f = {own, first, last, fcs, src, dst}
  task automatic offer(input logic [2:0] c, input logic [1:0] t, input logic [5:0] f);
    @(posedge i_clock);
    {i_desc_valid, i_desc_ch, i_desc_type} <= {1'b1, c, t};
    {i_desc_own, i_desc_first, i_desc_last, i_desc_fcs_sup, i_desc_src_port, i_desc_dst_port} <= f;
    @(posedge i_clock);
    i_desc_valid <= 1'b0;
  endtask
  // Bounded wait for go k: 0 tx, 1 rx, 2 copy
  task automatic wait_go(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge i_clock);
      n++;
    end
    while (gos[k] !== 1'b1 && n < 60);
    if (gos[k] !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  // MAC stall stops frames without touching offers
  task automatic hold_mac(input logic s);
    @(posedge i_clock);
    stall <= s;
    repeat (2) @(posedge i_clock);
  endtask
  // ---------------
  // Scenarios
  // ---------------
  task automatic t_single();
    offer(3'h1, `DT_TXB, 6'b111100);
    wait_go(0);
    chk({o_tx_ring, o_tx_port, o_tx_first, o_tx_last, o_fcs_suppress}, 8'h1f);
  endtask
  task automatic t_priority();
    hold_mac(1'b1);
    offer(3'h3, `DT_TXB, 6'b111000);
    offer(3'h0, `DT_TXB, 6'b111000);
    stall <= 1'b0;
    wait_go(0);
    chk(o_tx_ring, 8'h00);
    wait_go(0);
    chk(o_tx_ring, 8'h03);
  endtask
  task automatic t_refuse();
    logic [7:0] cases [10] = '{8'he0, 8'hea, 8'he6, 8'hf4, 8'hc4, 8'hd6, 8'h8a, 8'h78, 8'h6c, 8'h48};
    foreach (cases[i])
    begin
      offer(cases[i][5:3], cases[i][2:1], {cases[i][6], 5'b11000});
      @(negedge i_clock);
      chk(o_desc_reject, cases[i][7]);
    end
  endtask
  task automatic t_rx();
    @(posedge i_clock);
    {i_rx_valid, i_rx_ring} <= 2'b11;
    @(posedge i_clock);
    i_rx_valid <= 1'b0;
    wait_go(1);
    chk({o_rx_port, o_rx_to_local}, 8'h03);
  endtask
  task automatic t_copy();
    hold_mac(1'b1);
    offer(3'h0, `DT_TXB, 6'b111000);
    offer(3'h6, `DT_COPY, 6'b111001);
    wait_go(2);
    chk({o_copy_ch, o_copy_rd_port, o_copy_wr_port}, 8'h19);
    @(posedge i_clock);
    stall <= 1'b0;
    wait_go(0);
    chk({o_tx_ring, o_tx_port}, 8'h00);
  endtask
  task automatic t_staged();
    offer(3'h2, `DT_TXB, 6'b110000);
    repeat (6)
    begin
      @(negedge i_clock);
      chk(o_tx_go, 8'h00);
    end
    offer(3'h2, `DT_TXB, 6'b101000);
    wait_go(0);
    chk({o_tx_staged, o_tx_first, o_tx_last}, 8'h06);
    wait_go(0);
    chk({o_tx_staged, o_tx_first, o_tx_last}, 8'h05);
  endtask
  task automatic t_buffer();
    @(posedge i_clock);
    {i_stage_we, i_stage_addr, i_stage_data} <= {1'b1, 13'h1fff, 8'ha5};
    @(posedge i_clock);
    {i_stage_we, i_buf_raddr} <= {1'b0, 13'h1fff};
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk(o_buf_rdata, 8'ha5);
  endtask
  // selections change only while no ring is busy
  task automatic spare_step(input logic [7:0] s, input logic [1:0] md, input logic [7:0] e);
    @(posedge i_clock);
    {i_port_sel, i_spare_mode} <= {s, md};
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk({o_port_a_active, o_port_b_active, o_spare_mode}, e);
  endtask
  task automatic t_spare();
    spare_step(8'h00, `PM_WIDE64, 8'h09);
    spare_step(8'hff, `PM_ADDR, 8'h06);
    spare_step(8'h22, `PM_WIDE64, 8'h0c);
  endtask
  task automatic t_full();
    logic [7:0] base;
    hold_mac(1'b1);
    base = sent;
    repeat (20) offer(3'h3, `DT_TXB, 6'b111000);
    repeat (2) @(negedge i_clock);
    chk(o_prefetch_ready[3], 8'h00);
    @(posedge i_clock);
    stall <= 1'b0;
    for (int n = 0; n < 100 && sent !== base + 8'h14; n++) @(negedge i_clock);
    chk(sent, base + 8'h14);
  endtask
  // Reset, then every scenario in turn
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    @(negedge i_clock);
    chk(o_prefetch_ready, 8'hff);
    t_single();
    t_priority();
    t_refuse();
    t_rx();
    t_copy();
    t_staged();
    t_buffer();
    t_spare();
    t_full();
    wrap_up();
  end
endmodule // ring_channel_dma_router_tb
`default_nettype wire
